// ### lmf_frame_ctrl.sv
// Frame controller: mode register, display RAM scan and backplane slots.
// Assumes the bus master keeps strobes one cycle long and never both at once.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`include "lmf_params.svh"
module lmf_frame_ctrl (
  input  logic                  clk_i,
  input  logic                  rst_n_i,
  input  lmf_pkg::lmf_bus_req_t bus_i,
  output logic [7:0]            reg_rdata_o,
  input  logic                  aux_tick_i,
  input  logic                  stop_mode_i,
  input  logic                  osc_fail_i,
  output lmf_pkg::lmf_drive_t   drive_o
);
  // ========================================================================
  // Declarations
  lmf_pkg::lmf_mode_t   mode_r;
  lmf_pkg::lmf_mode_t   act_r;
  lmf_pkg::lmf_state_t  state_r;
  lmf_pkg::lmf_status_t status_w;
  logic [1:0]  slot_r;
  logic [9:0]  tick_r;
  logic [2:0]  fetch_r;
  logic [39:0] shadow_r;
  logic [3:0]  bp_r;
  logic [44:0] seg_r;
  logic        disp_r;
  logic        pol_r;
  logic        rd_ram_r;
  logic [7:0]  rd_data_r;
  logic        ref_tick;
  logic        fault_w;
  logic        stop_gnd_w;
  logic        slot_end_w;
  logic        frame_end_w;
  logic        ram_wr_w;
  logic        ram_rd_w;
  logic [7:0]  ram_off_w;
  logic [4:0]  scan_idx_w;
  logic [7:0]  ram_a;
  logic [7:0]  ram_b;
  logic [47:0] row_w;

  function automatic logic ram_hit(input logic [7:0] a);
    return a >= `LMF_ADDR_RAM_FIRST && a <= `LMF_ADDR_RAM_LAST;
  endfunction

  // ========================================================================
  // Fault and slot timing
  // STOP halts the core clock, so only the auxiliary source survives it.
  assign stop_gnd_w = stop_mode_i && act_r.src != `LMF_SRC_AUX;
  assign fault_w    = osc_fail_i || stop_gnd_w;
  // One slot is one base period, so the frame scales with backplanes.
  assign slot_end_w = state_r == lmf_pkg::LMF_SHOW && ref_tick &&
                      tick_r == lmf_pkg::lmf_base_div(act_r.base) - 10'h001;
  assign frame_end_w = slot_end_w &&
                       {1'b0, slot_r} == lmf_pkg::lmf_backplanes(act_r.mux) - 3'h1;

  lmf_ref_div u_ref_div (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .run_i      (state_r != lmf_pkg::LMF_IDLE && !fault_w),
    .src_i      (act_r.src),
    .aux_tick_i (aux_tick_i),
    .ref_tick_o (ref_tick)
  );

  // ========================================================================
  // Register bus
  assign ram_off_w = bus_i.addr - `LMF_ADDR_RAM_FIRST;
  assign ram_wr_w  = bus_i.wr && ram_hit(bus_i.addr);
  assign ram_rd_w  = bus_i.rd && ram_hit(bus_i.addr);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mode_r <= `LMF_MODE_RESET;
    end else if (bus_i.wr && bus_i.addr == `LMF_ADDR_MODE) begin
      mode_r <= bus_i.wdata;
    end
  end

  assign status_w = '{src: act_r.src, slot: slot_r, stop_gnd: stop_gnd_w,
                      osc_fail: osc_fail_i, disp_on: disp_r};

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !bus_i.rd) begin
      rd_data_r <= 8'h00;
      rd_ram_r  <= 1'b0;
    end else begin
      rd_ram_r <= ram_rd_w;
      if (bus_i.addr == `LMF_ADDR_MODE) begin
        rd_data_r <= mode_r;
      end else if (bus_i.addr == `LMF_ADDR_STATUS) begin
        rd_data_r <= status_w;
      end else begin
        rd_data_r <= 8'h00;
      end
    end
  end

  assign reg_rdata_o = rd_data_r | (rd_ram_r ? ram_a : 8'h00);

  // ========================================================================
  // Display RAM
  // Six bytes per backplane: slot times six plus the byte in the row.
  assign scan_idx_w = {1'b0, slot_r, 2'b00} + {2'b00, slot_r, 1'b0} +
                      {2'b00, fetch_r};

  lmf_ram u_ram (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .wr_i      (ram_wr_w),
    .waddr_i   (ram_off_w[4:0]),
    .wdata_i   (bus_i.wdata),
    .a_addr_i  (ram_off_w[4:0]),
    .a_rdata_o (ram_a),
    .b_addr_i  (scan_idx_w),
    .b_rdata_o (ram_b)
  );

  // ========================================================================
  // Frame sequencer
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_r <= lmf_pkg::LMF_IDLE;
      act_r   <= `LMF_MODE_RESET;
      slot_r  <= 2'h0;
      pol_r   <= 1'b0;
    end else begin
      unique case (state_r)
        lmf_pkg::LMF_IDLE: begin
          // No frame runs, so a new setting can be taken at once.
          act_r  <= mode_r;
          slot_r <= 2'h0;
          if (!osc_fail_i && !stop_mode_i && lmf_pkg::lmf_cfg_ok(mode_r)) begin
            state_r <= lmf_pkg::LMF_FETCH;
          end
        end
        lmf_pkg::LMF_FETCH: begin
          if (fault_w) begin
            state_r <= lmf_pkg::LMF_IDLE;
          end else if (fetch_r == `LMF_BYTES_PER_BP) begin
            state_r <= lmf_pkg::LMF_SHOW;
          end
        end
        lmf_pkg::LMF_SHOW: begin
          if (fault_w) begin
            state_r <= lmf_pkg::LMF_IDLE;
          end else if (frame_end_w) begin
            act_r   <= mode_r;
            slot_r  <= 2'h0;
            pol_r   <= ~pol_r;
            state_r <= lmf_pkg::lmf_cfg_ok(mode_r) ? lmf_pkg::LMF_FETCH
                                                   : lmf_pkg::LMF_IDLE;
          end else if (slot_end_w) begin
            slot_r  <= slot_r + 2'h1;
            state_r <= lmf_pkg::LMF_FETCH;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || state_r != lmf_pkg::LMF_SHOW) begin
      tick_r <= 10'h000;
    end else if (ref_tick) begin
      tick_r <= tick_r + 10'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || state_r != lmf_pkg::LMF_FETCH) begin
      fetch_r <= 3'h0;
    end else begin
      fetch_r <= fetch_r + 3'h1;
    end
  end

  // Read data lag the address by a cycle, so byte k lands at count k+1.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      shadow_r <= 40'h00_0000_0000;
    end else if (state_r == lmf_pkg::LMF_FETCH && fetch_r != 3'h0) begin
      shadow_r <= {ram_b, shadow_r[39:8]};
    end
  end

  assign row_w = {ram_b, shadow_r};

  // ========================================================================
  // Drive outputs
  // Segments and backplanes are held at ground whenever the driver is off.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || state_r == lmf_pkg::LMF_IDLE || fault_w) begin
      disp_r <= 1'b0;
      bp_r   <= 4'h0;
      seg_r  <= 45'h0000_0000_0000;
    end else if (state_r == lmf_pkg::LMF_FETCH && fetch_r == `LMF_BYTES_PER_BP) begin
      disp_r <= 1'b1;
      bp_r   <= 4'h1 << slot_r;
      seg_r  <= row_w[47:`LMF_SEG_LSB];
    end
  end

  assign drive_o = '{backplane: bp_r, segment: seg_r, drive_en: disp_r,
                     bias_en: disp_r,
                     half_bias: disp_r && act_r.mux == `LMF_MUX_HALF,
                     polarity: disp_r && pol_r};

  // ========================================================================
  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_fail_ground;
    osc_fail_i |=> drive_o.backplane == 4'h0 && drive_o.segment == 45'h0 &&
                   !drive_o.drive_en;
  endproperty
  a_fail_ground: assert property (p_fail_ground) else $error("fail not grounded");

  property p_stop_ground;
    stop_mode_i && act_r.src != `LMF_SRC_AUX |=> !drive_o.drive_en ##1 !drive_o.drive_en;
  endproperty
  a_stop_ground: assert property (p_stop_ground) else $error("stop not grounded");

  property p_bias_off;
    state_r == lmf_pkg::LMF_IDLE |=> !drive_o.bias_en;
  endproperty
  a_bias_off: assert property (p_bias_off) else $error("bias on while off");

  property p_src_at_frame_end;
    !$stable(act_r.src) |-> $past(frame_end_w) || $past(state_r) == lmf_pkg::LMF_IDLE;
  endproperty
  a_src_at_frame_end: assert property (p_src_at_frame_end) else $error("early source");

  // After a frame end the last backplane stands through the fetch while the new mode is
  // already latched, so that window is left out. The bound is one bit wider for 1/4 duty.
  property p_bp_active;
    drive_o.drive_en && (state_r == lmf_pkg::LMF_SHOW || slot_r != 2'h0)
      |-> $onehot(drive_o.backplane) &&
          {1'b0, drive_o.backplane} < (5'h01 << lmf_pkg::lmf_backplanes(act_r.mux));
  endproperty
  a_bp_active: assert property (p_bp_active) else $error("bad backplane");

  // A frame ends while its last active backplane is shown, then restarts at the first.
  property p_frame_slots;
    frame_end_w && !fault_w
      |-> drive_o.backplane == (4'h1 << (lmf_pkg::lmf_backplanes(act_r.mux) - 3'h1))
          ##1 slot_r == 2'h0;
  endproperty
  a_frame_slots: assert property (p_frame_slots) else $error("frame slot count");

  property p_slot_len;
    state_r == lmf_pkg::LMF_SHOW |-> tick_r < lmf_pkg::lmf_base_div(act_r.base);
  endproperty
  a_slot_len: assert property (p_slot_len) else $error("slot overrun");

  // Half bias goes with 1/2 duty only, and then only the first two backplanes are driven.
  property p_half_bias;
    drive_o.drive_en && state_r == lmf_pkg::LMF_SHOW
      |-> drive_o.half_bias == (act_r.mux == `LMF_MUX_HALF) &&
          (!drive_o.half_bias || drive_o.backplane[3:2] == 2'b00);
  endproperty
  a_half_bias: assert property (p_half_bias) else $error("half bias flag");

  property p_mode_read;
    bus_i.rd && bus_i.addr == `LMF_ADDR_MODE |=> reg_rdata_o == $past(mode_r);
  endproperty
  a_mode_read: assert property (p_mode_read) else $error("mode read");

  property p_seg_show;
    state_r == lmf_pkg::LMF_FETCH && fetch_r == `LMF_BYTES_PER_BP && !fault_w
      |=> drive_o.segment == $past(row_w[47:`LMF_SEG_LSB]);
  endproperty
  a_seg_show: assert property (p_seg_show) else $error("segment data");

  c_quad_frame: cover property (frame_end_w && act_r.mux == `LMF_MUX_QUAD);
  c_aux_stop: cover property (stop_mode_i && drive_o.drive_en);
  c_src_switch: cover property (frame_end_w && mode_r.src != act_r.src);
  c_fail: cover property (osc_fail_i && drive_o.drive_en);
endmodule

// ### lmf_params.svh
// Constants of the multiplexed LCD frame controller.
// Assumes it is included by bare name, once per compile unit or guarded.
// Summary of operation
// - Mux field picks backplanes: 00 four, 01 one, 10 two, 11 three.
// - Base field divides reference by 512,386,256,192,128,96,64; code 111 reserved.
// - Frame lasts one base period per active backplane, so rate is base over count.
// - Bias divider is off whenever the driver is off.
// - Thirds bias serves 1/1, 1/3, 1/4; half bias is flagged for 1/2.
// - A set RAM bit turns its element on; a clear bit keeps it off.
// - Display RAM is never cleared or initialised by reset.
// - RAM bytes of unused backplanes stay plain read/write storage.
// - Six bytes per backplane from E0; segments from bit 3 of first byte.
// - STOP while on internal clock switches off and grounds all lines.
// - Source field: 000 off, 001 auxiliary, 010/111 reserved, others divide core clock.
// - Source change applies at frame end, or at once while the display is off; software feeds clocks before STOP.
// - Mode register at DC: mux bits 7-6, source 5-3, base 2-0.
// - Source codes 011..110 divide core clock by 32, 64, 128, 256.
// - Oscillator failure grounds every segment and backplane line.
`ifndef LMF_PARAMS_SVH
`define LMF_PARAMS_SVH
// ==========================================================================
// Register map
`define LMF_ADDR_MODE      8'hdc
`define LMF_ADDR_STATUS    8'hf8
`define LMF_ADDR_RAM_FIRST 8'he0
`define LMF_ADDR_RAM_LAST  8'hf7
`define LMF_MODE_RESET     8'h00
`define LMF_RAM_DEPTH      5'h18
`define LMF_BYTES_PER_BP   3'h6
// ==========================================================================
// Field codes
`define LMF_MUX_QUAD   2'h0
`define LMF_MUX_SINGLE 2'h1
`define LMF_MUX_HALF   2'h2
`define LMF_MUX_THIRD  2'h3
`define LMF_SRC_OFF    3'h0
`define LMF_SRC_AUX    3'h1
`define LMF_SRC_RES_A  3'h2
`define LMF_SRC_RES_B  3'h7
`define LMF_BASE_RES   3'h7
`define LMF_SEG_LSB    3
// ==========================================================================
// Divisors
`define LMF_DIV_512 10'h200
`define LMF_DIV_386 10'h182
`define LMF_DIV_256 10'h100
`define LMF_DIV_192 10'h0c0
`define LMF_DIV_128 10'h080
`define LMF_DIV_96  10'h060
`define LMF_DIV_64  10'h040
`define LMF_INT_32  9'h020
`define LMF_INT_64  9'h040
`define LMF_INT_128 9'h080
`define LMF_INT_256 9'h100
`endif

// ### lmf_pkg.sv
// Types and shared decoding of the LCD frame controller.
// Assumes lmf_params.svh is on the include path.
`include "lmf_params.svh"
package lmf_pkg;
  // ========================================================================
  // Carriers
  typedef struct packed {
    logic [1:0] mux;
    logic [2:0] src;
    logic [2:0] base;
  } lmf_mode_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } lmf_bus_req_t;
  typedef struct packed {
    logic [3:0]  backplane;
    logic [44:0] segment;
    logic        drive_en;
    logic        bias_en;
    logic        half_bias;
    logic        polarity;
  } lmf_drive_t;
  typedef struct packed {
    logic [2:0] src;
    logic [1:0] slot;
    logic       stop_gnd;
    logic       osc_fail;
    logic       disp_on;
  } lmf_status_t;
  typedef enum logic [1:0] {LMF_IDLE, LMF_FETCH, LMF_SHOW} lmf_state_t;
  // ========================================================================
  // Decoding
  function automatic logic [2:0] lmf_backplanes(input logic [1:0] mux);
    unique case (mux)
      `LMF_MUX_QUAD:   return 3'h4;
      `LMF_MUX_SINGLE: return 3'h1;
      `LMF_MUX_HALF:   return 3'h2;
      `LMF_MUX_THIRD:  return 3'h3;
    endcase
  endfunction
  function automatic logic [9:0] lmf_base_div(input logic [2:0] base);
    case (base)
      3'h0:    return `LMF_DIV_512;
      3'h1:    return `LMF_DIV_386;
      3'h2:    return `LMF_DIV_256;
      3'h3:    return `LMF_DIV_192;
      3'h4:    return `LMF_DIV_128;
      3'h5:    return `LMF_DIV_96;
      default: return `LMF_DIV_64;
    endcase
  endfunction
  function automatic logic [8:0] lmf_int_div(input logic [2:0] src);
    case (src)
      3'h3:    return `LMF_INT_32;
      3'h4:    return `LMF_INT_64;
      3'h5:    return `LMF_INT_128;
      default: return `LMF_INT_256;
    endcase
  endfunction
  // Reserved codes are treated as a display that stays off.
  function automatic logic lmf_cfg_ok(input lmf_mode_t m);
    return m.src != `LMF_SRC_OFF && m.src != `LMF_SRC_RES_A &&
           m.src != `LMF_SRC_RES_B && m.base != `LMF_BASE_RES;
  endfunction
endpackage

// ### lmf_ram.sv
// Display RAM of the LCD frame controller: one write port, two read ports.
// Assumes indices below the depth; other indices read as zero.
`timescale 1ns/1ps
`include "lmf_params.svh"
module lmf_ram (
  input  logic       clk_i,
  input  logic       rst_n_i,
  input  logic       wr_i,
  input  logic [4:0] waddr_i,
  input  logic [7:0] wdata_i,
  input  logic [4:0] a_addr_i,
  output logic [7:0] a_rdata_o,
  input  logic [4:0] b_addr_i,
  output logic [7:0] b_rdata_o
);
  logic [7:0] mem [0:23];

  // The array has no reset, so its content is kept through reset.
  always_ff @(posedge clk_i) begin
    if (wr_i && waddr_i < `LMF_RAM_DEPTH) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      a_rdata_o <= 8'h00;
      b_rdata_o <= 8'h00;
    end else begin
      a_rdata_o <= (a_addr_i < `LMF_RAM_DEPTH) ? mem[a_addr_i] : 8'h00;
      b_rdata_o <= (b_addr_i < `LMF_RAM_DEPTH) ? mem[b_addr_i] : 8'h00;
    end
  end
endmodule

// ### lmf_ref_div.sv
// Reference tick source: divided core clock or auxiliary oscillator tick.
// Assumes aux_tick_i is a one-cycle pulse synchronous to clk_i.
`timescale 1ns/1ps
`include "lmf_params.svh"
module lmf_ref_div (
  input  logic       clk_i,
  input  logic       rst_n_i,
  input  logic       run_i,
  input  logic [2:0] src_i,
  input  logic       aux_tick_i,
  output logic       ref_tick_o
);
  logic [8:0] cnt_r;
  logic [8:0] div_w;
  logic       aux_w;

  assign div_w = lmf_pkg::lmf_int_div(src_i);
  assign aux_w = (src_i == `LMF_SRC_AUX);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !run_i || aux_w) begin
      cnt_r <= 9'h000;
    end else if (cnt_r == div_w - 9'h001) begin
      cnt_r <= 9'h000;
    end else begin
      cnt_r <= cnt_r + 9'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !run_i) begin
      ref_tick_o <= 1'b0;
    end else if (aux_w) begin
      ref_tick_o <= aux_tick_i;
    end else begin
      ref_tick_o <= (cnt_r == div_w - 9'h001);
    end
  end
endmodule

// ### lmf_panel_model.sv
// Glass panel model: follows backplane slots and flags DC bias on the panel.
// Assumes the drive carrier of lmf_pkg and the same clock as the controller.
`timescale 1ns/1ps
module lmf_panel_model (
  input  wire logic                clk_i,
  input  wire logic                rst_n_i,
  input  wire lmf_pkg::lmf_drive_t drive_i,
  output logic                     slot_new_o,
  output logic [1:0]               slot_idx_o,
  output logic                     frame_end_o,
  output logic                     fault_o
);
  logic [3:0] bp_r;
  logic       pol_r;
  // ========
  // Slot tracking
  assign slot_new_o  = drive_i.backplane != 4'h0 && drive_i.backplane != bp_r;
  assign frame_end_o = drive_i.polarity != pol_r;
  always_comb begin
    slot_idx_o = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (drive_i.backplane[i]) begin
        slot_idx_o = i[1:0];
      end
    end
  end
  always_ff @(posedge clk_i) begin
    bp_r  <= drive_i.backplane;
    pol_r <= drive_i.polarity;
  end
  // ========
  // Bias hazards
  // An undriven panel must see ground on every line, or its elements take DC bias.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fault_o <= 1'b0;
    end else if (!drive_i.drive_en && (drive_i.backplane != 4'h0 ||
                 drive_i.segment != 45'h0)) begin
      fault_o <= 1'b1;
    end else if (drive_i.drive_en && $countones(drive_i.backplane) != 1) begin
      fault_o <= 1'b1;
    end
  end
endmodule

// ### lcd_mux_frame_controller_test.sv
// Self-checking bench of the LCD frame controller against a RAM image model.
// Assumes lmf_pkg, lmf_params.svh and the panel model are compiled first.
`timescale 1ns/1ps
`include "lmf_params.svh"
module lcd_mux_frame_controller_test;
  logic                  clk_i;
  logic                  rst_n_i;
  lmf_pkg::lmf_bus_req_t bus_i;
  logic [7:0]            reg_rdata_o;
  logic                  aux_tick_i;
  logic                  stop_mode_i;
  logic                  osc_fail_i;
  lmf_pkg::lmf_drive_t   drive_o;
  logic                  slot_new;
  logic [1:0]            slot_idx;
  logic                  frame_end;
  logic                  fault;
  logic [7:0]            ram_m [24];
  logic [7:0]            d;
  logic [7:0]            m8;
  int                    failures;
  int                    check_count;
  int                    n;
  int                    t;
  int                    k;
  int                    div_tab [7] = '{512, 386, 256, 192, 128, 96, 64};
  logic [7:0]            off_modes [4] = '{8'h06, 8'h16, 8'h3e, 8'h0f};

  lmf_frame_ctrl lmf_frame_ctrl_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .bus_i(bus_i), .reg_rdata_o(reg_rdata_o),
    .aux_tick_i(aux_tick_i), .stop_mode_i(stop_mode_i), .osc_fail_i(osc_fail_i),
    .drive_o(drive_o));
  lmf_panel_model lmf_panel_model_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .drive_i(drive_o), .slot_new_o(slot_new),
    .slot_idx_o(slot_idx), .frame_end_o(frame_end), .fault_o(fault));

  // ========
  // Clock, auxiliary ticks and watchdog
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // One auxiliary tick every second cycle, the fastest rate the controller takes.
  always @(posedge clk_i) aux_tick_i <= ~aux_tick_i;
  initial begin
    repeat (90000) @(posedge clk_i);
    failures++;
    give_verdict();
  end

  // ========
  // Tasks
  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk_rng(input string name, input int lo, input int hi, input int got);
    check_count++;
    if (got < lo || got > hi) begin
      failures++;
      $display("[ERR] %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask
  // Both bus tasks start right after a rising edge and end one edge after release.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    bus_i <= '{a, v, 1'b1, 1'b0};
    @(posedge clk_i);
    bus_i <= '0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    bus_i <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_i);
    bus_i <= '0;
    @(posedge clk_i);
    v = reg_rdata_o;
  endtask
  task automatic do_reset();
    if (rst_n_i === 1'b1) begin
      chk("panel_dc_free", 1'b0, fault);
    end
    rst_n_i     <= 1'b0;
    stop_mode_i <= 1'b0;
    osc_fail_i  <= 1'b0;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
  endtask
  // Kind 0 waits for a new slot, 1 for a frame end, 2 for the display to come on.
  task automatic wait_ev(input int which, output int cnt);
    logic hit;
    cnt = 0;
    hit = 1'b0;
    while (!hit && cnt < 40000) begin
      @(posedge clk_i);
      cnt++;
      hit = which == 0 ? slot_new === 1'b1 :
            which == 1 ? frame_end === 1'b1 : drive_o.drive_en === 1'b1;
    end
    if (!hit) begin
      failures++;
      $display("[ERR] wait kind %0d expected event seen none", which);
    end
  endtask
  function automatic logic [44:0] exp_seg(input int s);
    logic [47:0] row;
    for (int b = 0; b < 6; b++) begin
      row[b*8 +: 8] = ram_m[6*s+b];
    end
    return row[47:3];
  endfunction
  task automatic give_verdict();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ========
  // Main sequence
  initial begin
    failures    = 0;
    check_count = 0;
    rst_n_i     = 1'b0;
    bus_i       = '0;
    aux_tick_i  = 1'b0;
    stop_mode_i = 1'b0;
    osc_fail_i  = 1'b0;
    void'($urandom(24833));
    do_reset();
    chk("drive_after_reset", 64'h0, drive_o);
    rd(`LMF_ADDR_MODE, d);
    chk("mode_reset", `LMF_MODE_RESET, d);
    wr(`LMF_ADDR_STATUS, 8'hff);
    rd(`LMF_ADDR_STATUS, d);
    chk("status_read_only", 8'h00, d);
    rd(8'h10, d);
    chk("unmapped_read", 8'h00, d);
    for (int i = 0; i < 24; i++) begin
      ram_m[i] = 8'($urandom);
      wr(`LMF_ADDR_RAM_FIRST + i[7:0], ram_m[i]);
    end
    for (int i = 0; i < 24; i++) begin
      rd(`LMF_ADDR_RAM_FIRST + i[7:0], d);
      chk("ram_readback", ram_m[i], d);
    end
    for (int i = 0; i < 4; i++) begin
      m8 = 8'($urandom);
      wr(`LMF_ADDR_MODE, m8);
      rd(`LMF_ADDR_MODE, d);
      chk("mode_readback", m8, d);
    end
    foreach (off_modes[i]) begin
      do_reset();
      wr(`LMF_ADDR_MODE, off_modes[i]);
      repeat (40) @(posedge clk_i);
      chk("display_off", 1'b0, drive_o.drive_en);
    end
    for (int m = 0; m < 4; m++) begin
      n = m == 0 ? 4 : m;
      do_reset();
      wr(`LMF_ADDR_MODE, {m[1:0], 3'h1, 3'h6});
      for (int s = 0; s < (n == 1 ? 1 : n + 1); s++) begin
        wait_ev(0, k);
        chk("slot_index", s % n, slot_idx);
        chk("segments", exp_seg(s % n), drive_o.segment);
        chk("bias_en", 1'b1, drive_o.bias_en);
        chk("half_bias", m == 2, drive_o.half_bias);
      end
      if (m == 3) begin
        for (int i = 18; i < 24; i++) begin
          ram_m[i] = 8'($urandom);
          wr(`LMF_ADDR_RAM_FIRST + i[7:0], ram_m[i]);
          rd(`LMF_ADDR_RAM_FIRST + i[7:0], d);
          chk("spare_ram", ram_m[i], d);
        end
      end
    end
    for (int b = 0; b < 8; b++) begin
      n = b == 7 ? 4 : 1;
      t = div_tab[b == 7 ? 6 : b];
      do_reset();
      wr(`LMF_ADDR_MODE, {(n == 4 ? 2'h0 : 2'h1), 3'h1, (b == 7 ? 3'h6 : b[2:0])});
      wait_ev(1, k);
      wait_ev(1, k);
      chk_rng("frame_cycles", n * (2 * t + 5), n * (2 * t + 10), k);
    end
    for (int c = 3; c < 7; c++) begin
      t = 32 << (c - 3);
      do_reset();
      wr(`LMF_ADDR_MODE, {2'h1, c[2:0], 3'h6});
      wait_ev(2, k);
      wait_ev(1, k);
      chk_rng("core_div_cycles", 63 * t - 16, 65 * t + 16, k);
    end
    stop_mode_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("stop_grounds", 64'h0, drive_o);
    do_reset();
    wr(`LMF_ADDR_MODE, 8'h0e);
    wait_ev(2, k);
    stop_mode_i <= 1'b1;
    wr(`LMF_ADDR_MODE, 8'h4e);
    wait_ev(0, k);
    chk("mode_at_frame_end", 2'h1, slot_idx);
    wait_ev(1, k);
    repeat (300) @(posedge clk_i);
    chk("single_backplane", 4'h1, drive_o.backplane);
    osc_fail_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("osc_fail_grounds", 64'h0, drive_o);
    do_reset();
    for (int i = 0; i < 24; i++) begin
      rd(`LMF_ADDR_RAM_FIRST + i[7:0], d);
      chk("ram_kept", ram_m[i], d);
    end
    chk("panel_dc_free", 1'b0, fault);
    give_verdict();
  end
endmodule
